// >>> bench/sram_model.sv
`timescale 1ns/100ps
module sram_model
(
    input  wire sram_ctrl_pkg::pins_t pins,
    input  wire logic [7:0]           host_data,
    input  wire logic                 host_oe_n,
    output logic [7:0]                bus,
    output logic                      clash
);
    logic [7:0] mem [0:131071];
    logic [7:0] rdata;
    wire        drv;
    // No clock, no refresh, no power-up delay on select
    wire        sel = !pins.sel_low_n && pins.sel_high;
    wire        rd  = sel && pins.strobe_n && !pins.gate_n;
    // Late turn-on and slow turn-off, harsher than an ideal part
    assign #(4, 7) drv = rd;
    assign #20 rdata = mem[pins.addr];
    always @*
    begin
        if (sel && !pins.strobe_n && !host_oe_n)
            mem[pins.addr] = host_data;
    end
    // Released bus shows inverted data, never a tidy value
    assign bus = drv ? rdata : (!host_oe_n ? host_data : ~rdata);
    initial clash = 1'b0;
    always @*
    begin
        if (drv && !host_oe_n)
            clash = 1'b1;
    end
endmodule // sram_model

// >>> bench/tb.sv
`timescale 1ns/100ps
module tb;
    logic                 sys_clk   = 1'b0;
    logic                 srst      = 1'b1;
    logic                 req_valid = 1'b0;
    sram_ctrl_pkg::req_t  req       = '0;
    sram_ctrl_pkg::pins_t pins;
    logic                 req_ready;
    logic                 rsp_valid;
    logic                 data_oe_n;
    logic                 clash;
    logic [7:0]           rsp_data;
    logic [7:0]           data_in;
    logic [7:0]           data_out;
    int                   fails        = 0;
    int                   total_checks = 0;
    int                   cycles       = 0;

    always #20 sys_clk = ~sys_clk;

    sram_host u_dut (.sys_clk(sys_clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
                     .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .data_in(data_in),
                     .data_out(data_out), .data_oe_n(data_oe_n));
    sram_model u_mem (.pins(pins), .host_data(data_out), .host_oe_n(data_oe_n), .bus(data_in), .clash(clash));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run needs under a hundred cycles
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            fails++;
            close_out();
        end
    end

    task automatic issue(input logic wr, input logic [16:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req       <= '{write: wr, addr: a, wdata: d};
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 20);
        req_valid <= 1'b0;
    endtask

    task automatic do_write(input logic [16:0] a, input logic [7:0] d);
        int low;
        low = 0;
        issue(1'b1, a, d);
        repeat (3)
        begin
            @(negedge sys_clk);
            if (pins.strobe_n === 1'b0)
            begin
                low++;
                check("write selects", {pins.sel_low_n, pins.sel_high}, 2'b01);
                check("write addr", pins.addr, a);
                check("write data", {data_oe_n, data_out}, {1'b0, d});
            end
        end
        check("strobe cycles", low, sram_ctrl_pkg::WR_PULSE_CYC);
    endtask

    task automatic do_read(input logic [16:0] a, input logic [7:0] exp);
        issue(1'b0, a, 8'h00);
        @(negedge sys_clk);
        check("read pins", {pins.addr, pins.gate_n, data_oe_n, rsp_valid}, {a, 3'b010});
        @(negedge sys_clk);
        check("read data", {rsp_valid, rsp_data}, {1'b1, exp});
        @(negedge sys_clk);
        check("rsp pulse", rsp_valid, 1'b0);
    endtask

    task automatic t_reset;
        @(negedge sys_clk);
        check("reset pins", {pins, data_oe_n, rsp_valid, req_ready}, {17'h00000, 4'b1011, 3'b101});
    endtask

    task automatic t_fill_and_read;
        logic [16:0] ad [4] = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
        logic [7:0]  dd [4] = '{8'h5A, 8'hA5, 8'hFF, 8'h00};
        foreach (ad[i])
            do_write(ad[i], dd[i]);
        foreach (ad[i])
            do_read(ad[i], dd[i]);
    endtask

    task automatic t_overwrite;
        do_write(17'h00000, 8'hC3);
        do_read(17'h00000, 8'hC3);
        do_read(17'h1FFFF, 8'hA5);
        check("bus clash", clash, 1'b0);
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_fill_and_read();
        t_overwrite();
        close_out();
    end
endmodule // tb

// >>> hw/sram_ctrl_pkg.sv
package sram_ctrl_pkg;

    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 40;

    // Timing of the slowest speed grade, in ns
    localparam int T_CYCLE_NS      = 20;
    localparam int T_SEL_TO_END_NS = 15;
    localparam int T_ADDR_TO_END_NS = 15;
    localparam int T_PULSE_NS      = 15;
    localparam int T_DATA_SETUP_NS = 9;
    localparam int T_WR_HIGHZ_NS   = 8;
    localparam int T_OE_ACCESS_NS  = 8;
    localparam int T_OE_HIGHZ_NS   = 7;

    function automatic int ns_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Write pulse must also cover turnoff plus data setup when the gate is low
    localparam int WR_PULSE_CYC = ns_up((T_PULSE_NS > T_WR_HIGHZ_NS + T_DATA_SETUP_NS)
                                       ? T_PULSE_NS : T_WR_HIGHZ_NS + T_DATA_SETUP_NS);
    localparam int TURNOFF_CYC  = ns_up(T_WR_HIGHZ_NS > T_OE_HIGHZ_NS ? T_WR_HIGHZ_NS : T_OE_HIGHZ_NS);
    localparam int READ_CYC     = ns_up(T_CYCLE_NS > T_OE_ACCESS_NS ? T_CYCLE_NS : T_OE_ACCESS_NS);
    localparam int CNT_W        = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              sel_low_n;
        logic              sel_high;
        logic              strobe_n;
        logic              gate_n;
    } pins_t;

    typedef enum logic [2:0] {ST_IDLE, ST_TURNOFF, ST_WRITE, ST_READ, ST_DONE} state_t;

endpackage

// >>> hw/sram_host.sv
`timescale 1ns/100ps
module sram_host
(
    input  wire logic                            sys_clk,
    input  wire logic                            srst,
    input  wire logic                            req_valid,
    output logic                                 req_ready,
    input  wire sram_ctrl_pkg::req_t             req,
    output logic                                 rsp_valid,
    output logic [sram_ctrl_pkg::DATA_W-1:0]     rsp_data,
    output sram_ctrl_pkg::pins_t                 pins,
    input  wire logic [sram_ctrl_pkg::DATA_W-1:0] data_in,
    output logic [sram_ctrl_pkg::DATA_W-1:0]     data_out,
    output logic                                 data_oe_n
);

    sram_ctrl_pkg::state_t                    state;
    sram_ctrl_pkg::state_t                    next_state;
    logic [sram_ctrl_pkg::CNT_W-1:0]          cnt;
    logic [sram_ctrl_pkg::CNT_W-1:0]          next_cnt;
    sram_ctrl_pkg::req_t                      cur;
    sram_ctrl_pkg::req_t                      next_cur;
    logic [sram_ctrl_pkg::DATA_W-1:0]         next_rsp_data;
    logic                                     next_rsp_valid;

    // Counter loads n-1, so each count must fit the counter
    if (sram_ctrl_pkg::WR_PULSE_CYC > (1 << sram_ctrl_pkg::CNT_W) ||
        sram_ctrl_pkg::READ_CYC > (1 << sram_ctrl_pkg::CNT_W) ||
        sram_ctrl_pkg::TURNOFF_CYC > (1 << sram_ctrl_pkg::CNT_W))
    begin : g_cnt_check
        $error("Timing counts exceed counter width");
    end

    function automatic logic [sram_ctrl_pkg::CNT_W-1:0] cyc(input int n);
        int m;
        m = n - 1;
        return m[sram_ctrl_pkg::CNT_W-1:0];
    endfunction

    assign req_ready = (state == sram_ctrl_pkg::ST_IDLE);

    always_comb
    begin
        next_state     = state;
        next_cnt       = cnt;
        next_cur       = cur;
        next_rsp_data  = rsp_data;
        next_rsp_valid = 1'b0;
        case (state)
            sram_ctrl_pkg::ST_IDLE:
            begin
                if (req_valid)
                begin
                    next_cur = req;
                    if (req.write)
                    begin
                        // Gate stays high from idle, yet wait out any device turnoff
                        next_state = sram_ctrl_pkg::ST_TURNOFF;
                        next_cnt   = cyc(sram_ctrl_pkg::TURNOFF_CYC);
                    end
                    else
                    begin
                        next_state = sram_ctrl_pkg::ST_READ;
                        next_cnt   = cyc(sram_ctrl_pkg::READ_CYC);
                    end
                end
            end
            sram_ctrl_pkg::ST_TURNOFF:
            begin
                if (cnt == sram_ctrl_pkg::CNT_ZERO)
                begin
                    next_state = sram_ctrl_pkg::ST_WRITE;
                    next_cnt   = cyc(sram_ctrl_pkg::WR_PULSE_CYC);
                end
                else
                    next_cnt = cnt - 1'b1;
            end
            sram_ctrl_pkg::ST_WRITE:
            begin
                if (cnt == sram_ctrl_pkg::CNT_ZERO)
                    next_state = sram_ctrl_pkg::ST_DONE;
                else
                    next_cnt = cnt - 1'b1;
            end
            sram_ctrl_pkg::ST_READ:
            begin
                if (cnt == sram_ctrl_pkg::CNT_ZERO)
                begin
                    // Sample before the address moves; hold time covers us
                    next_rsp_data  = data_in;
                    next_rsp_valid = 1'b1;
                    next_state     = sram_ctrl_pkg::ST_DONE;
                end
                else
                    next_cnt = cnt - 1'b1;
            end
            sram_ctrl_pkg::ST_DONE:
                next_state = sram_ctrl_pkg::ST_IDLE;
            default:
                next_state = sram_ctrl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state     <= sram_ctrl_pkg::ST_IDLE;
            cnt       <= sram_ctrl_pkg::CNT_ZERO;
            cur       <= '0;
            rsp_data  <= '0;
            rsp_valid <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            cur       <= next_cur;
            rsp_data  <= next_rsp_data;
            rsp_valid <= next_rsp_valid;
        end
    end

    // Pin outputs registered; selects span turnoff and pulse, and all
    // controls release on one edge with address and data held through it.
    sram_ctrl_pkg::pins_t next_pins;
    logic [sram_ctrl_pkg::DATA_W-1:0] next_data_out;
    logic                             next_data_oe_n;

    always_comb
    begin
        next_pins.addr      = cur.addr;
        next_pins.sel_low_n = 1'b1;
        next_pins.sel_high  = 1'b0;
        next_pins.strobe_n  = 1'b1;
        next_pins.gate_n    = 1'b1;
        next_data_out       = cur.wdata;
        next_data_oe_n      = 1'b1;
        case (next_state)
            sram_ctrl_pkg::ST_TURNOFF:
            begin
                next_pins.addr      = next_cur.addr;
                next_pins.sel_low_n = 1'b0;
                next_pins.sel_high  = 1'b1;
            end
            sram_ctrl_pkg::ST_WRITE:
            begin
                next_pins.sel_low_n = 1'b0;
                next_pins.sel_high  = 1'b1;
                next_pins.strobe_n  = 1'b0;
                next_data_oe_n      = 1'b0;
            end
            sram_ctrl_pkg::ST_READ:
            begin
                next_pins.addr      = next_cur.addr;
                next_pins.sel_low_n = 1'b0;
                next_pins.sel_high  = 1'b1;
                next_pins.gate_n    = 1'b0;
            end
            default:
            begin
                next_pins.addr = cur.addr;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pins      <= '{addr: '0, sel_low_n: 1'b1, sel_high: 1'b0, strobe_n: 1'b1, gate_n: 1'b1};
            data_out  <= '0;
            data_oe_n <= 1'b1;
        end
        else
        begin
            pins      <= next_pins;
            data_out  <= next_data_out;
            data_oe_n <= next_data_oe_n;
        end
    end

    sequence s_write_start;
        $fell(pins.strobe_n);
    endsequence

    sequence s_write_end;
        $rose(pins.strobe_n);
    endsequence

    a_bus_quiet_gate: assert property (@(posedge sys_clk) disable iff (srst)
        !data_oe_n |-> pins.gate_n) else $error("Driving data while gate low");
    a_write_overlap: assert property (@(posedge sys_clk) disable iff (srst)
        !pins.strobe_n |-> (!pins.sel_low_n && pins.sel_high && !data_oe_n))
        else $error("Strobe low outside select overlap");
    a_select_before_end: assert property (@(posedge sys_clk) disable iff (srst)
        s_write_start |-> $past(!pins.sel_low_n)) else $error("Select not set before strobe");
    a_pulse_width: assert property (@(posedge sys_clk) disable iff (srst)
        s_write_end |-> $past(!pins.strobe_n && pins.gate_n, sram_ctrl_pkg::WR_PULSE_CYC))
        else $error("Strobe pulse too short");
    a_addr_stable: assert property (@(posedge sys_clk) disable iff (srst)
        s_write_end |-> ($stable(pins.addr) && ($past(pins.addr, 2) == pins.addr)))
        else $error("Address moved during write");
    a_data_stable: assert property (@(posedge sys_clk) disable iff (srst)
        s_write_end |-> ($past(!data_oe_n) && $stable(data_out))) else $error("Data moved during write");
    a_turnoff_wait: assert property (@(posedge sys_clk) disable iff (srst)
        s_write_start |-> $past(data_oe_n)) else $error("Data driven before turnoff wait");
    a_read_answer: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(pins.gate_n) |-> ##1 (rsp_valid && pins.gate_n)) else $error("Read answer late");
    a_read_sample: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(rsp_valid) |-> $past(!pins.gate_n && !pins.sel_low_n && pins.sel_high))
        else $error("Read sampled while device not driving");
    a_gate_single: assert property (@(posedge sys_clk) disable iff (srst)
        !pins.gate_n |-> pins.strobe_n) else $error("Gate low during write");

endmodule // sram_host
